// ---- verilog/mgc_consts.vh ----
// constants shared by the gain and mode control block
`ifndef MGC_CONSTS_VH
`define MGC_CONSTS_VH
`define MGC_ADDR_GAIN 8'h01
`define MGC_ADDR_MODE 8'h02
`define MGC_ADDR_DATA_FIRST 8'h03
`define MGC_ADDR_DATA_LAST 8'h08
`define MGC_GAIN_RESET 8'h20
`define MGC_MODE_RESET 8'h01
`define MGC_GAIN_MSB 7
`define MGC_GAIN_LSB 5
`define MGC_BIT_FAST 7
`define MGC_BIT_LOWPWR 5
`define MGC_BIT_SPI3 2
`define MGC_MD_MSB 1
`define MGC_MD_LSB 0
`define MGC_MD_CONT 2'h0
`define MGC_MD_SINGLE 2'h1
`define MGC_MD_IDLE 2'h2
`define MGC_RATE_SLOWEST 3'h0
`define MGC_CLK_HZ 100000000
`define MGC_CHZ_PER_HZ 100
`define MGC_RATE0_CHZ 75
`define MGC_RATE1_CHZ 150
`define MGC_RATE2_CHZ 300
`define MGC_RATE3_CHZ 750
`define MGC_RATE4_CHZ 1500
`define MGC_RATE5_CHZ 3000
`define MGC_RATE6_CHZ 7500
`define MGC_RATE7_CHZ 22000
`define MGC_SENS0 11'd1370
`define MGC_SENS1 11'd1090
`define MGC_SENS2 11'd820
`define MGC_SENS3 11'd660
`define MGC_SENS4 11'd440
`define MGC_SENS5 11'd390
`define MGC_SENS6 11'd330
`define MGC_SENS7 11'd230
`define MGC_AXES 3
`define MGC_ALL_READ 6'h3f
`endif

// ---- verilog/mgc_fifo2.v ----
// small valid/ready buffer for converter words
`timescale 1ns/1ps
module mgc_fifo2 #(
  parameter W = 12,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ---- verilog/mgc_top.v ----
// gain and operating mode control with measurement sequencing
//
// Contract
// RULE1 - three-bit gain field, shared by all axes
// RULE2 - gain codes map to fixed sensitivities
// RULE3 - gain register resets to 0x20
// RULE4 - host keeps low gain bits zero
// RULE5 - new gain applies from second measurement
// RULE6 - host lowers gain on saturation
// RULE7 - mode register resets to 0x01
// RULE8 - top mode bit enables fast bus
// RULE9 - host keeps mode bits 6,3 zero
// RULE10 - low power forces slowest rate, one sample
// RULE11 - mode bit 2 selects three-wire spi
// RULE12 - continuous mode measures repeatedly, sets ready
// RULE13 - first continuous set after two periods
// RULE14 - single mode measures once, then idle
// RULE15 - single result and ready held until read
// RULE16 - codes 10 and 11 mean idle
// RULE17 - idle stops measuring, keeps registers
// RULE18 - partial data read freezes output registers
// RULE19 - writing single while idle starts measurement
`timescale 1ns/1ps
`include "mgc_consts.vh"
module mgc_top #(
  parameter CLK_HZ = `MGC_CLK_HZ,
  parameter PERIOD_DIV = 1,
  parameter CW = 12
) (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [2:0] cfg_rate,
  input wire cfg_write,
  input wire conv_clk,
  input wire conv_valid,
  input wire [CW-1:0] conv_data,
  output reg conv_ready,
  output reg meas_start,
  output reg meas_enable,
  output reg [2:0] meas_gain,
  output reg [10:0] meas_sens,
  output reg [2:0] meas_rate,
  output reg meas_avg_one,
  output reg i2c_fast_enable,
  output reg spi_wire_select,
  output reg result_ready_pin
);
  function [31:0] period_cycles;
    input [2:0] code;
    reg [63:0] chz;
    reg [63:0] cyc;
    begin
      case (code)
        3'h0: chz = `MGC_RATE0_CHZ;
        3'h1: chz = `MGC_RATE1_CHZ;
        3'h2: chz = `MGC_RATE2_CHZ;
        3'h3: chz = `MGC_RATE3_CHZ;
        3'h4: chz = `MGC_RATE4_CHZ;
        3'h5: chz = `MGC_RATE5_CHZ;
        3'h6: chz = `MGC_RATE6_CHZ;
        default: chz = `MGC_RATE7_CHZ;
      endcase
      // never longer than the nominal period, so floor division; never below one cycle
      cyc = (64'd1 * CLK_HZ * `MGC_CHZ_PER_HZ) / chz / PERIOD_DIV;
      period_cycles = (cyc > 64'd1) ? cyc[31:0] : 32'd1;
    end
  endfunction

  reg [7:0] gain_cfg_bits_r;
  reg [7:0] opmode_bits_r;
  reg [2:0] gain_stage_r;
  reg [31:0] period_cnt_r;
  reg first_wait_r;
  reg start_pending_r;
  reg single_wait_r;
  reg [1:0] stage_cnt_r;
  reg [15:0] stage_r [0:`MGC_AXES-1];
  reg [15:0] data_r [0:`MGC_AXES-1];
  reg [5:0] read_mask_r;
  reg [2:0] clk_sync_r;
  reg [1:0] valid_sync_r;
  reg [CW-1:0] data_sync1_r;
  reg [CW-1:0] data_sync2_r;
  integer i;

  localparam [7:0] GAIN_RST = `MGC_GAIN_RESET;
  localparam [2:0] GAIN_RST_CODE = GAIN_RST[`MGC_GAIN_MSB:`MGC_GAIN_LSB];

  wire [1:0] md = opmode_bits_r[`MGC_MD_MSB:`MGC_MD_LSB];
  wire is_cont = (md == `MGC_MD_CONT);
  wire is_idle = md[1]; // RULE16
  wire lowpwr = opmode_bits_r[`MGC_BIT_LOWPWR];
  wire [2:0] rate_eff = lowpwr ? `MGC_RATE_SLOWEST : cfg_rate; // RULE10
  wire [31:0] period_now = period_cycles(rate_eff);
  wire wr_gain = reg_wr && (reg_addr == `MGC_ADDR_GAIN);
  wire wr_mode = reg_wr && (reg_addr == `MGC_ADDR_MODE);
  wire restart = wr_mode || cfg_write || wr_gain;
  wire rd_data = reg_rd && (reg_addr >= `MGC_ADDR_DATA_FIRST) && (reg_addr <= `MGC_ADDR_DATA_LAST);
  wire [7:0] rd_off = reg_addr - `MGC_ADDR_DATA_FIRST;
  wire [2:0] rd_idx = rd_off[2:0];
  wire [5:0] read_mask_nxt = read_mask_r | (rd_data ? (6'h01 << rd_idx) : 6'h00);
  wire locked = (read_mask_r != 6'h00); // RULE18
  wire all_read = (read_mask_nxt == `MGC_ALL_READ);
  // a first data read in the publish cycle would mix two sets
  wire publish = (stage_cnt_r == `MGC_AXES) && !locked && !rd_data; // RULE18
  wire period_end = (period_cnt_r >= period_now - 32'd1);
  wire cont_start = is_cont && period_end && !first_wait_r && !restart; // RULE12 RULE13
  wire single_start = start_pending_r && !is_idle && !is_cont && !restart; // RULE19
  wire start_now = cont_start || single_start;

  // converter link: conv_valid and conv_data pass two flops, conv_clk three; conv_data is held by the converter while valid
  wire conv_rise = clk_sync_r[1] && !clk_sync_r[2];
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [CW-1:0] fifo_out_data;
  wire pop = fifo_out_valid && (stage_cnt_r < `MGC_AXES);

  mgc_fifo2 #(.W(CW), .DEPTH(2), .AW(1)) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(conv_rise && valid_sync_r[1]),
    .in_ready(fifo_in_ready),
    .in_data(data_sync2_r),
    .out_valid(fifo_out_valid),
    .out_ready(stage_cnt_r < `MGC_AXES),
    .out_data(fifo_out_data)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync_r <= 3'h0;
      valid_sync_r <= 2'h0;
      data_sync1_r <= {CW{1'b0}};
      data_sync2_r <= {CW{1'b0}};
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], conv_clk};
      valid_sync_r <= {valid_sync_r[0], conv_valid};
      data_sync1_r <= conv_data;
      data_sync2_r <= data_sync1_r;
    end
  end

  // register file and mode sequencing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_cfg_bits_r <= `MGC_GAIN_RESET; // RULE3
      opmode_bits_r <= `MGC_MODE_RESET; // RULE7
      start_pending_r <= 1'b1;
      single_wait_r <= 1'b0;
      period_cnt_r <= 32'h0;
      first_wait_r <= 1'b1;
    end else begin
      if (wr_gain) begin
        gain_cfg_bits_r <= reg_wdata;
      end
      if (wr_mode) begin
        opmode_bits_r <= reg_wdata;
      end else if (publish && single_wait_r) begin
        opmode_bits_r[`MGC_MD_MSB:`MGC_MD_LSB] <= `MGC_MD_IDLE; // RULE14
      end
      // any other mode write drops a start not yet launched
      if (wr_mode) begin
        start_pending_r <= (reg_wdata[`MGC_MD_MSB:`MGC_MD_LSB] == `MGC_MD_SINGLE); // RULE19
      end else if (single_start) begin
        start_pending_r <= 1'b0;
      end
      if (single_start) begin
        single_wait_r <= 1'b1;
      end else if (publish || (wr_mode && reg_wdata[`MGC_MD_MSB:`MGC_MD_LSB] != `MGC_MD_SINGLE)) begin
        single_wait_r <= 1'b0;
      end
      // a write restarts the two-period wait before the first set
      if (restart || !is_cont) begin
        period_cnt_r <= 32'h0;
        first_wait_r <= 1'b1; // RULE13
      end else if (period_end) begin
        period_cnt_r <= 32'h0;
        first_wait_r <= 1'b0;
      end else begin
        period_cnt_r <= period_cnt_r + 32'd1;
      end
    end
  end

  // result staging and output registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_cnt_r <= 2'h0;
      read_mask_r <= 6'h00;
      for (i = 0; i < `MGC_AXES; i = i + 1) begin
        stage_r[i] <= 16'h0000;
        data_r[i] <= 16'h0000;
      end
    end else begin
      if (pop) begin
        stage_r[stage_cnt_r] <= {{(16-CW){fifo_out_data[CW-1]}}, fifo_out_data};
        stage_cnt_r <= stage_cnt_r + 2'h1;
      end else if (publish) begin
        stage_cnt_r <= 2'h0;
        for (i = 0; i < `MGC_AXES; i = i + 1) begin
          data_r[i] <= stage_r[i]; // RULE12 RULE15
        end
      end
      read_mask_r <= all_read ? 6'h00 : read_mask_nxt; // RULE18
    end
  end

  // outputs, all from flops
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      conv_ready <= 1'b0;
      meas_start <= 1'b0;
      meas_enable <= 1'b0;
      meas_gain <= GAIN_RST_CODE;
      gain_stage_r <= GAIN_RST_CODE;
      meas_sens <= `MGC_SENS1;
      meas_rate <= 3'h0;
      meas_avg_one <= 1'b0;
      i2c_fast_enable <= 1'b0;
      spi_wire_select <= 1'b0;
      result_ready_pin <= 1'b0;
    end else begin
      if (reg_rd) begin
        case (reg_addr)
          `MGC_ADDR_GAIN: reg_rdata <= gain_cfg_bits_r;
          `MGC_ADDR_MODE: reg_rdata <= opmode_bits_r;
          default: begin
            if (rd_data) begin
              reg_rdata <= rd_idx[0] ? data_r[rd_idx[2:1]][7:0] : data_r[rd_idx[2:1]][15:8];
            end else begin
              reg_rdata <= 8'h00;
            end
          end
        endcase
      end
      conv_ready <= fifo_in_ready;
      meas_start <= start_now;
      meas_enable <= !is_idle || single_wait_r; // RULE17
      if (start_now) begin
        // one-measurement lag on gain changes
        meas_gain <= gain_stage_r; // RULE5
        gain_stage_r <= gain_cfg_bits_r[`MGC_GAIN_MSB:`MGC_GAIN_LSB]; // RULE1
      end
      case (meas_gain) // RULE2
        3'h0: meas_sens <= `MGC_SENS0;
        3'h1: meas_sens <= `MGC_SENS1;
        3'h2: meas_sens <= `MGC_SENS2;
        3'h3: meas_sens <= `MGC_SENS3;
        3'h4: meas_sens <= `MGC_SENS4;
        3'h5: meas_sens <= `MGC_SENS5;
        3'h6: meas_sens <= `MGC_SENS6;
        default: meas_sens <= `MGC_SENS7;
      endcase
      meas_rate <= rate_eff; // RULE10
      meas_avg_one <= lowpwr; // RULE10
      i2c_fast_enable <= opmode_bits_r[`MGC_BIT_FAST]; // RULE8
      spi_wire_select <= opmode_bits_r[`MGC_BIT_SPI3]; // RULE11
      // new data wins over the clear from a finished read
      if (publish) begin
        result_ready_pin <= 1'b1; // RULE12 RULE15
      end else if (all_read) begin
        result_ready_pin <= 1'b0; // RULE15
      end
    end
  end
endmodule

// ---- dv/mgc_props_properties.sv ----
// port assertions for gain and mode control
`timescale 1ns/1ps
module mgc_props (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire meas_start,
  input wire meas_enable,
  input wire [2:0] meas_gain,
  input wire [10:0] meas_sens,
  input wire [2:0] meas_rate,
  input wire meas_avg_one,
  input wire i2c_fast_enable,
  input wire spi_wire_select,
  input wire result_ready_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  localparam [87:0] SENS = {11'd230, 11'd330, 11'd390, 11'd440, 11'd660, 11'd820, 11'd1090, 11'd1370};
  wire mode_wr = reg_wr && reg_addr == 8'h02;
  sequence s_idle_wr;
    mode_wr && reg_wdata[1];
  endsequence
  sequence s_path_off;
    ##[1:3] !meas_enable;
  endsequence
  a_sens_table: assert property (meas_sens == SENS[$past(meas_gain) * 11 +: 11])
    else $error("sensitivity does not match gain code");
  a_lowpwr_rate: assert property (meas_avg_one |-> meas_rate == 3'h0)
    else $error("low power without slowest rate");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  a_fast_copy: assert property (!$stable(i2c_fast_enable) |-> $past(mode_wr) || $past(mode_wr, 2))
    else $error("fast bus bit moved without mode write");
  a_spi_copy: assert property (!$stable(spi_wire_select) |-> $past(mode_wr) || $past(mode_wr, 2))
    else $error("wire select moved without mode write");
  a_ready_held: assert property ($fell(result_ready_pin) |-> $past(reg_rd) || $past(reg_rd, 2))
    else $error("ready dropped without a read");
  a_gain_at_start: assert property (!$stable(meas_gain) |-> meas_start || $past(meas_start))
    else $error("gain moved outside a measurement start");
  a_idle_stops: assert property (s_idle_wr |-> s_path_off)
    else $error("idle write left path enabled");
endmodule
bind mgc_top mgc_props mgc_props_inst (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .meas_start,
  .meas_enable, .meas_gain, .meas_sens, .meas_rate, .meas_avg_one, .i2c_fast_enable, .spi_wire_select,
  .result_ready_pin);

// ---- dv/mgc_conv_model.sv ----
// converter stand-in answering each start seen while not busy with three words
`timescale 1ns/1ps
module mgc_conv_model (
  input wire meas_start,
  input wire conv_ready,
  input wire slow,
  input wire [11:0] word_base,
  output logic conv_clk,
  output logic conv_valid,
  output logic [11:0] conv_data
);
  int n = 0;
  initial begin
    conv_clk = 0;
    conv_valid = 0;
    conv_data = 12'h000;
  end
  // link clock stands still between words; starts seen while busy are missed
  always @(posedge meas_start) begin
    for (int i = 0; i < 3; i++) begin
      if (slow) #1000;
      wait (conv_ready === 1'b1);
      conv_valid = 1;
      conv_data = word_base + n[11:0];
      #62.5 conv_clk = 1;
      #62.5 conv_clk = 0;
      conv_valid = 0;
      // released line must not look like the old word
      conv_data = ~conv_data;
      n++;
    end
  end
endmodule

// ---- dv/mgc_top_tb.sv ----
// self-checking bench for gain and mode control
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module mgc_top_tb;
  localparam [87:0] SENS = {11'd230, 11'd330, 11'd390, 11'd440, 11'd660, 11'd820, 11'd1090, 11'd1370};
  localparam int P = 454;
  logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, cfg_write = 0, slow = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, d;
  logic [2:0] cfg_rate = 0, pg = 3'h1;
  logic [11:0] base = 0;
  int n_errors = 0, tests_run = 0, nw = 0, k;
  wire [7:0] reg_rdata;
  wire [11:0] conv_data;
  wire [10:0] meas_sens;
  wire [2:0] meas_gain, meas_rate;
  wire conv_clk, conv_valid, conv_ready, meas_start, meas_enable, meas_avg_one;
  wire i2c_fast_enable, spi_wire_select, result_ready_pin;
  // short periods keep continuous runs brief
  mgc_top #(.PERIOD_DIV(1000)) mgc_top_inst (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cfg_rate, .cfg_write, .conv_clk, .conv_valid, .conv_data, .conv_ready, .meas_start,
    .meas_enable, .meas_gain, .meas_sens, .meas_rate, .meas_avg_one, .i2c_fast_enable, .spi_wire_select,
    .result_ready_pin);
  mgc_conv_model mgc_conv_model_inst (.meas_start, .conv_ready, .slow, .word_base(base), .conv_clk,
    .conv_valid, .conv_data);
  initial forever #5 clk = ~clk;
  task final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(input [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  function automatic [7:0] xb(input int a);
    logic [11:0] w;
    w = base + nw[11:0] + 12'((a - 3) / 2);
    return (a % 2) ? {{4{w[11]}}, w[11:8]} : w[7:0];
  endfunction
  task automatic get_set(input [7:0] em);
    int j;
    for (j = 0; j < 3000 && !result_ready_pin; j++) @(negedge clk);
    for (j = 3; j < 9; j++) begin
      if (j == 8) `CHK(result_ready_pin, 1'b1)
      rd(j[7:0]);
      `CHK(d, xb(j))
      if (j % 2) `CHK(d[7:3] == 5'h00 || d[7:3] == 5'h1f, 1'b1)
    end
    nw += 3;
    if (em != 0) begin
      `CHK(result_ready_pin, 1'b0)
      rd(8'h02);
      `CHK(d, em)
    end
  endtask
  task automatic measure(input [2:0] eg, input go);
    int j;
    slow = $urandom % 2;
    if (go) wr(8'h02, 8'h01);
    for (j = 0; j < 50 && go && !meas_start; j++) @(negedge clk);
    repeat (2) @(negedge clk);
    `CHK(meas_gain, eg)
    `CHK(meas_sens, SENS[eg * 11 +: 11])
    `CHK(meas_enable, 1'b1)
    get_set(8'h02);
  endtask
  initial begin
    void'($urandom(32'h6933));
    base = $urandom;
    repeat (16) @(negedge clk);
    reset_n = 1;
    wr(8'h09, 8'hff);
    rd(8'h01);
    `CHK(d, 8'h20)
    rd(8'h02);
    `CHK(d, 8'h01)
    rd(8'h0b);
    `CHK(d, 8'h00)
    measure(3'h1, 0);
    for (int g = 0; g < 8; g++) begin
      wr(8'h01, {g[2:0], 5'h00});
      measure(pg, 1);
      measure(g[2:0], 1);
      pg = g[2:0];
    end
    cfg_rate = 3'($urandom | 1);
    wr(8'h02, 8'h86);
    repeat (3) @(negedge clk);
    `CHK({i2c_fast_enable, spi_wire_select, meas_enable}, 3'b110)
    `CHK({meas_avg_one, meas_rate}, {1'b0, cfg_rate})
    rd(8'h02);
    `CHK(d, 8'h86)
    wr(8'h02, 8'h23);
    repeat (3) @(negedge clk);
    `CHK({meas_avg_one, meas_rate, i2c_fast_enable, meas_enable}, 6'b100000)
    rd(8'h01);
    `CHK(d, 8'he0)
    cfg_rate = 3'h7;
    wr(8'h02, 8'h00);
    // a config write part way through must restart the two-period wait
    repeat (100) @(negedge clk);
    cfg_write = 1;
    @(negedge clk);
    cfg_write = 0;
    for (k = 0; k < 2000 && !meas_start; k++) @(negedge clk);
    `CHK(k > 2 * P - 9 && k < 2 * P + 9, 1'b1)
    for (k = 0; k < 2000 && !result_ready_pin; k++) @(negedge clk);
    rd(8'h03);
    `CHK(d, xb(3))
    // frozen set plus staged set leave the buffer to fill and refuse
    for (k = 0; k < 3000 && conv_ready; k++) @(negedge clk);
    `CHK(conv_ready, 1'b0)
    get_set(8'h00);
    repeat (20) @(negedge clk);
    `CHK(conv_ready, 1'b1)
    wr(8'h02, 8'h02);
    final_report;
  end
  initial begin
    #400000;
    n_errors++;
    final_report;
  end
endmodule
